// ---- rtl/twi_cfg_pkg.sv ----
// Constants shared by both ends of the two-wire configuration link
// Function
// - Bytes shift most significant bit first
// - Data changes only while clock low
// - Data pin undriven after power-up
// - Respond to nothing before a START
// - Ignore START while powering up or busy
// - STOP after read or volatile write: standby
// - STOP after non-volatile write starts cycle
// - Transmitter releases; receiver acks ninth clock
// - Device acks id, address and data bytes
// - Master acks each byte it reads; this master gives no ack clock, STOP follows its one read byte
// - Id byte: seven-bit code plus direction
// - Write: START, id, address, data, STOP
// - Ignore bus during non-volatile write cycle
// - Control register 08h selects storage target
// - Master waits 20 ms between NV writes; this master has no such wait and starts each request at once
// - Busy flag bit 0 shows NV cycle
// - Master never writes while busy reads 1; this master never reads busy before a write
// - Read: START, id, address, restart, id
// - Master ends read with STOP after byte
// - Target select bit 7 default zero
package twi_cfg_pkg;
    // Device code, arbitrary value
    localparam logic [6:0] DEV_CODE = 7'h2_5;
    localparam logic [7:0] CTRL_ADDR = 8'h0_8;
    localparam int SEL_BIT = 7;
    localparam int BUSY_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h0_0;
    localparam int NUM_REGS = 16;
    localparam int CLK_NS = 4;
    localparam int NV_WRITE_MS = 20;
    localparam int NV_WRITE_CYC = NV_WRITE_MS * 1000000 / CLK_NS;
    localparam int PWRUP_CYC = 16;
    localparam int HALF_SCL_CYC = 16;
endpackage

// ---- rtl/twi_link_if.sv ----
// Two-wire link carrying open-drain clock and data between the ends
`timescale 1ns/1ps
interface twi_link_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;
    // Open-drain wire level resolved from enables
    assign scl = !(scl_oe && !scl_o);
    assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
    modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe, input scl, sda);
    modport slave (output sda_s_o, sda_s_oe, input scl, sda);
endinterface

// ---- rtl/twi_sync.sv ----
// Two-stage synchroniser with edge outputs for a bus line
`timescale 1ns/1ps
module twi_sync (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // Line
    input wire logic i_line,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // Two flops then an edge stage; wires idle high
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
        end else begin
            meta_q <= i_line;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign o_level = sync_q;
    assign o_rise = sync_q && !last_q;
    assign o_fall = !sync_q && last_q;
endmodule

// ---- rtl/twi_cfg_slave.sv ----
// Device end: two-wire slave over the configuration registers
`timescale 1ns/1ps
module twi_cfg_slave #(
    parameter int NV_CYC = twi_cfg_pkg::NV_WRITE_CYC
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // Link
    twi_link_if.slave link,
    // Register view
    output logic [7:0] o_ctrl,
    output logic o_busy
);
    typedef enum logic [2:0] {ST_PWR, ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_NV}
        state_t;
    state_t state_q;
    logic scl_l, scl_r, scl_f, sda_l, sda_r, sda_f;
    logic [7:0] sh_q;
    logic [3:0] bit_q;
    logic [1:0] byte_q;
    logic rd_q, nv_pend_q;
    logic [7:0] rd_now;
    logic [7:0] addr_q;
    logic [31:0] cnt_q;
    logic [7:0] vreg_q [twi_cfg_pkg::NUM_REGS];
    logic [7:0] nvreg_q [twi_cfg_pkg::NUM_REGS];
    logic [7:0] ctrl_q;
    logic sda_oe_q;
    logic start_ev, stop_ev;

    twi_sync u_scl (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_line(link.scl),
        .o_level(scl_l), .o_rise(scl_r), .o_fall(scl_f));
    twi_sync u_sda (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_line(link.sda),
        .o_level(sda_l), .o_rise(sda_r), .o_fall(sda_f));

    assign start_ev = sda_f && scl_l;
    assign stop_ev = sda_r && scl_l;

    // Register read lookup, busy merged into control
    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h0_0;
        if (a == twi_cfg_pkg::CTRL_ADDR) begin
            v = ctrl_q;
        end else if (a < twi_cfg_pkg::NUM_REGS) begin
            v = ctrl_q[twi_cfg_pkg::SEL_BIT] ? vreg_q[a[3:0]] : nvreg_q[a[3:0]];
        end
        return v;
    endfunction

    // Protocol engine
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= ST_PWR;
            sh_q <= 8'h0_0;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            rd_q <= 1'b0;
            nv_pend_q <= 1'b0;
            addr_q <= 8'h0_0;
            cnt_q <= 32'h0000_0000;
            sda_oe_q <= 1'b0;
        end else if (state_q == ST_PWR) begin
            cnt_q <= cnt_q + 32'h0000_0001;
            if (cnt_q == twi_cfg_pkg::PWRUP_CYC) begin
                state_q <= ST_IDLE;
                cnt_q <= 32'h0000_0000;
            end
        end else if (state_q == ST_NV) begin
            sda_oe_q <= 1'b0;
            cnt_q <= cnt_q + 32'h0000_0001;
            if (cnt_q == NV_CYC - 1) begin
                state_q <= ST_IDLE;
                cnt_q <= 32'h0000_0000;
            end
        end else if (start_ev) begin
            // begin on START; repeated START too
            state_q <= ST_RX;
            bit_q <= 4'h0;
            // Byte count restarts; a repeated START keeps the address
            byte_q <= 2'h0;
            sda_oe_q <= 1'b0;
            nv_pend_q <= 1'b0;
        end else if (stop_ev) begin
            sda_oe_q <= 1'b0;
            state_q <= nv_pend_q ? ST_NV : ST_IDLE;
            nv_pend_q <= 1'b0;
            cnt_q <= 32'h0000_0000;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                ST_RX: begin
                    if (scl_r) begin
                        sh_q <= {sh_q[6:0], sda_l};
                        bit_q <= bit_q + 4'h1;
                    end
                    if (scl_f && bit_q == 4'h8) begin
                        if (byte_q == 2'h0) begin
                            if (sh_q[7:1] != twi_cfg_pkg::DEV_CODE) begin
                                state_q <= ST_IDLE;
                            end
                            rd_q <= sh_q[0];
                        end else if (byte_q == 2'h1) begin
                            addr_q <= sh_q;
                        end
                        if (sh_q[7:1] == twi_cfg_pkg::DEV_CODE || byte_q != 2'h0) begin
                            state_q <= ST_ACK;
                            sda_oe_q <= 1'b1;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_f) begin
                        bit_q <= 4'h0;
                        sda_oe_q <= 1'b0;
                        if (byte_q == 2'h0 && rd_q) begin
                            state_q <= ST_TX;
                            sh_q <= rd_now;
                            sda_oe_q <= !rd_now[7];
                            bit_q <= 4'h1;
                        end else begin
                            state_q <= ST_RX;
                            byte_q <= (byte_q == 2'h2) ? 2'h2 : byte_q + 2'h1;
                        end
                        if (byte_q == 2'h2 && !ctrl_q[twi_cfg_pkg::SEL_BIT]
                                && addr_q != twi_cfg_pkg::CTRL_ADDR) begin
                            nv_pend_q <= 1'b1;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_f) begin
                        if (bit_q == 4'h8) begin
                            sda_oe_q <= 1'b0;
                            state_q <= ST_MACK;
                        end else begin
                            sda_oe_q <= !sh_q[7 - bit_q[2:0]];
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    // master acks, else back to idle
                    if (scl_r && !sda_l) begin
                        state_q <= ST_TX;
                        addr_q <= addr_q + 8'h0_1;
                        sh_q <= rd_byte(addr_q + 8'h0_1);
                        bit_q <= 4'h0;
                    end
                    if (scl_r && sda_l) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Byte at the current address, sent when a read turns round
    always_comb begin
        rd_now = rd_byte(addr_q);
    end

    // Register writes when the data byte has been acked
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_q <= twi_cfg_pkg::CTRL_RESET;
            for (int i = 0; i < twi_cfg_pkg::NUM_REGS; i++) begin
                vreg_q[i] <= 8'h0_0;
                nvreg_q[i] <= 8'h0_0;
            end
        end else begin
            // busy tracks NV cycle, read only
            ctrl_q[twi_cfg_pkg::BUSY_BIT] <= (state_q == ST_NV);
            if (state_q == ST_ACK && scl_f && byte_q == 2'h2 && !start_ev && !stop_ev) begin
                if (addr_q == twi_cfg_pkg::CTRL_ADDR) begin
                    ctrl_q[7:1] <= sh_q[7:1];
                end else if (addr_q < twi_cfg_pkg::NUM_REGS) begin
                    vreg_q[addr_q[3:0]] <= sh_q;
                    if (!ctrl_q[twi_cfg_pkg::SEL_BIT]) begin
                        nvreg_q[addr_q[3:0]] <= sh_q;
                    end
                end
            end
        end
    end

    // pin undriven until acking or sending
    assign link.sda_s_o = 1'b0;
    assign link.sda_s_oe = sda_oe_q;

    // Register view outputs
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ctrl <= twi_cfg_pkg::CTRL_RESET;
            o_busy <= 1'b0;
        end else begin
            o_ctrl <= ctrl_q;
            o_busy <= (state_q == ST_NV);
        end
    end
endmodule

// ---- rtl/twi_cfg_master.sv ----
// Host end: two-wire master issuing single writes and random reads
`timescale 1ns/1ps
module twi_cfg_master #(
    parameter int HALF = twi_cfg_pkg::HALF_SCL_CYC
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // Link
    twi_link_if.master link,
    // Request
    input wire logic i_req,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    // Answer
    output logic o_busy,
    output logic o_done,
    output logic o_nack,
    output logic [7:0] o_rdata
);
    typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_STOP, M_DONE} mstate_t;
    mstate_t st_q;
    logic [15:0] div_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [2:0] idx_q;
    logic [7:0] sh_q;
    logic scl_q, sda_q;
    logic rd_q, nack_q, meta_q, sync_q;
    logic [7:0] addr_q, wd_q;
    logic tick;

    assign tick = (div_q == 16'(HALF - 1));

    // Synchronise returning data
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= link.sda;
            sync_q <= meta_q;
        end
    end

    // Byte to send at each step: id, addr, data / id, addr, id read
    function automatic logic [7:0] tx_byte(input logic [2:0] i, input logic r);
        logic [7:0] b;
        b = {twi_cfg_pkg::DEV_CODE, 1'b0};
        if (i == 3'h1) begin
            b = addr_q;
        end else if (i == 3'h2) begin
            // direction bit set on second id
            b = r ? {twi_cfg_pkg::DEV_CODE, 1'b1} : wd_q;
        end
        return b;
    endfunction

    // Sequencer, each bit is four quarter phases
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q <= M_IDLE;
            div_q <= 16'h0000;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            idx_q <= 3'h0;
            sh_q <= 8'h0_0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            rd_q <= 1'b0;
            nack_q <= 1'b0;
            addr_q <= 8'h0_0;
            wd_q <= 8'h0_0;
            o_done <= 1'b0;
            o_nack <= 1'b0;
            o_rdata <= 8'h0_0;
        end else begin
            o_done <= 1'b0;
            div_q <= tick ? 16'h0000 : div_q + 16'h0001;
            unique case (st_q)
                M_IDLE: begin
                    if (i_req) begin
                        st_q <= M_START;
                        rd_q <= i_rd;
                        addr_q <= i_addr;
                        wd_q <= i_wdata;
                        idx_q <= 3'h0;
                        nack_q <= 1'b0;
                        ph_q <= 2'h0;
                        div_q <= 16'h0000;
                    end
                end
                M_START: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0) begin
                        sda_q <= 1'b1;
                    end else if (ph_q == 2'h1) begin
                        scl_q <= 1'b1;
                    end else if (ph_q == 2'h2) begin
                        sda_q <= 1'b0;
                    end else begin
                        scl_q <= 1'b0;
                        st_q <= M_BIT;
                        bit_q <= 4'h0;
                        sh_q <= tx_byte(idx_q, rd_q);
                    end
                end
                M_BIT: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0) begin
                        if (idx_q == 3'h3) begin
                            // release for read byte, last bit then STOP with no ack
                            sda_q <= 1'b1;
                        end else begin
                            sda_q <= (bit_q == 4'h8) ? 1'b1 : sh_q[7];
                        end
                    end else if (ph_q == 2'h1) begin
                        scl_q <= 1'b1;
                    end else if (ph_q == 2'h2) begin
                        if (idx_q == 3'h3 && bit_q != 4'h8) begin
                            sh_q <= {sh_q[6:0], sync_q};
                        end else if (bit_q != 4'h8) begin
                            sh_q <= {sh_q[6:0], 1'b0};
                        end else if (idx_q != 3'h3 && sync_q) begin
                            nack_q <= 1'b1;
                        end
                    end else begin
                        scl_q <= 1'b0;
                        bit_q <= bit_q + 4'h1;
                        if (idx_q == 3'h3 && bit_q == 4'h7) begin
                            st_q <= M_STOP;
                            o_rdata <= sh_q;
                        end else if (bit_q == 4'h8) begin
                            bit_q <= 4'h0;
                            idx_q <= idx_q + 3'h1;
                            if (nack_q || (!rd_q && idx_q == 3'h2)) begin
                                st_q <= M_STOP;
                            end else if (rd_q && idx_q == 3'h1) begin
                                st_q <= M_START;
                            end else if (rd_q && idx_q == 3'h2) begin
                                sh_q <= 8'h0_0;
                            end else begin
                                sh_q <= tx_byte(idx_q + 3'h1, rd_q);
                            end
                        end
                    end
                end
                M_STOP: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0) begin
                        sda_q <= 1'b0;
                    end else if (ph_q == 2'h1) begin
                        scl_q <= 1'b1;
                    end else if (ph_q == 2'h2) begin
                        sda_q <= 1'b1;
                    end else begin
                        st_q <= M_DONE;
                    end
                end
                M_DONE: begin
                    o_done <= 1'b1;
                    o_nack <= nack_q;
                    st_q <= M_IDLE;
                end
                default: st_q <= M_IDLE;
            endcase
        end
    end

    // Busy flag and open-drain drive
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (st_q != M_IDLE) || i_req;
        end
    end

    assign link.scl_o = 1'b0;
    assign link.scl_oe = !scl_q;
    assign link.sda_m_o = 1'b0;
    assign link.sda_m_oe = !sda_q;
endmodule

// ---- tb/twi_cfg_asserts.sv ----
// Concurrent checks on the two-wire link between the master and slave ends
`timescale 1ns/1ps
module twi_cfg_asserts (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // Link
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_m_oe,
    input wire logic sda_s_oe
);
    logic scl_q;
    logic sda_q;
    logic open_q;
    logic dir_q;
    logic [5:0] rise_q;
    logic start_w;
    logic stop_w;
    logic rise_w;

    // Bus conditions seen on the sampled lines
    assign start_w = scl && scl_q && sda_q && !sda;
    assign stop_w = scl && scl_q && !sda_q && sda;
    assign rise_w = scl && !scl_q;

    // Line history for edge detection
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    // Frame open flag and clock rise count since the last start
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            open_q <= 1'b0;
            rise_q <= 6'h00;
        end else if (start_w) begin
            open_q <= 1'b1;
            rise_q <= 6'h00;
        end else if (stop_w) begin
            open_q <= 1'b0;
        end else if (rise_w && rise_q != 6'h3f) begin
            rise_q <= rise_q + 6'h01;
        end
    end

    // Direction bit of the latest identification byte
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            dir_q <= 1'b0;
        end else if (rise_w && open_q && rise_q == 6'd7) begin
            dir_q <= sda;
        end
    end

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    // slave data moves with clock low
    chk_slave_low_clk: assert property ($changed(sda_s_oe) |-> !scl)
        else $error("slave data changed while clock high");
    chk_reset_release: assert property ($rose(i_rstn) |-> !sda_s_oe [*8])
        else $error("slave drove data right after reset");
    chk_start_first: assert property (sda_s_oe |-> open_q)
        else $error("slave drove data outside a frame");
    chk_ack_length: assert property ($rose(sda_s_oe) |-> sda_s_oe [*8])
        else $error("slave low pulse too short");
    chk_id_msb_first: assert property (rise_w && open_q && rise_q < 6'd7 |->
        sda == twi_cfg_pkg::DEV_CODE[3'd6 - rise_q[2:0]])
        else $error("id bit out of order");
    chk_id_ack_slot: assert property (rise_w && open_q && rise_q == 6'd8 |->
        sda_s_oe && !sda_m_oe)
        else $error("id byte not acknowledged by slave alone");
    // second acknowledge slot of a write-direction id released by master
    chk_second_slot: assert property (
        rise_w && open_q && !dir_q && rise_q == 6'd17 |-> !sda_m_oe)
        else $error("master drove the second acknowledge slot");
    chk_data_ack: assert property (rise_w && open_q && rise_q == 6'd26 |-> sda_s_oe)
        else $error("write data byte not acknowledged");
    chk_stop_quiet: assert property (stop_w |-> !sda_s_oe [*8])
        else $error("slave drove data after stop");

    // Main scenarios reached
    cov_write_ack: cover property (rise_w && open_q && rise_q == 6'd26 && sda_s_oe);
    cov_restart: cover property (start_w && open_q);
    cov_stop: cover property (stop_w);
endmodule

// ---- tb/tb_i2c_slave_nv_register_access.sv ----
// Self-checking bench joining master and slave ends over the two-wire link
`timescale 1ns/1ps
module tb_i2c_slave_nv_register_access;
    localparam int NV_SIM = 1000;
    localparam logic [7:0] ID_W = {twi_cfg_pkg::DEV_CODE, 1'b0};
    typedef struct packed {
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } row_t;
    logic i_mclk;
    logic i_rstn;
    logic i_req;
    logic i_rd;
    logic [7:0] i_addr;
    logic [7:0] i_wdata;
    logic m_busy;
    logic m_done;
    logic m_nack;
    logic [7:0] m_rdata;
    logic [7:0] ctrl_a;
    logic busy_a;
    logic busy_b;
    int n_fail;
    int comparisons;
    int n;
    row_t rows [5];
    twi_link_if link ();
    twi_link_if link_b ();

    // Both ends on the main link, a lone slave on the second link
    twi_cfg_master u_twi_cfg_master (.i_mclk(i_mclk), .i_rstn(i_rstn), .link(link),
        .i_req(i_req), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .o_busy(m_busy),
        .o_done(m_done), .o_nack(m_nack), .o_rdata(m_rdata));
    twi_cfg_slave #(.NV_CYC(NV_SIM)) u_twi_cfg_slave (.i_mclk(i_mclk), .i_rstn(i_rstn),
        .link(link), .o_ctrl(ctrl_a), .o_busy(busy_a));
    twi_cfg_slave #(.NV_CYC(NV_SIM)) u_twi_cfg_slave_b (.i_mclk(i_mclk), .i_rstn(i_rstn),
        .link(link_b), .o_ctrl(), .o_busy(busy_b));
    twi_cfg_asserts u_twi_cfg_asserts (.i_mclk(i_mclk), .i_rstn(i_rstn), .scl(link.scl),
        .sda(link.sda), .sda_m_oe(link.sda_m_oe), .sda_s_oe(link.sda_s_oe));

    // Clock
    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t ns: seen %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic give_up();
        n_fail++;
        $display("[ERR] %0t ns: wait limit ran out", $time);
        finish_test();
    endtask

    // One master transfer, waiting for its completion pulse
    task automatic xfer(input logic rd, input logic [7:0] addr, input logic [7:0] wdata);
        int k;
        @(posedge i_mclk);
        #1;
        i_req = 1'b1;
        i_rd = rd;
        i_addr = addr;
        i_wdata = wdata;
        @(posedge i_mclk);
        #1;
        i_req = 1'b0;
        check({7'h00, m_busy}, 8'h01);
        for (k = 0; k < 20000 && m_done !== 1'b1; k++) begin
            @(posedge i_mclk);
            #1;
        end
        if (k == 20000) give_up();
    endtask

    // Quarter of a 64 ns link clock on the second link
    task automatic q();
        repeat (4) @(posedge i_mclk);
        #1;
    endtask

    task automatic bb_start();
        link_b.sda_m_oe = 1'b0;
        link_b.scl_oe = 1'b0;
        q();
        link_b.sda_m_oe = 1'b1;
        q();
        link_b.scl_oe = 1'b1;
        q();
    endtask

    task automatic bb_stop();
        link_b.sda_m_oe = 1'b1;
        q();
        link_b.scl_oe = 1'b0;
        q();
        link_b.sda_m_oe = 1'b0;
        q();
    endtask

    // Sends a byte msb first, then compares the acknowledge seen with exp
    task automatic bb_send(input logic [7:0] b, input logic exp);
        logic ack;
        for (int i = 7; i >= 0; i--) begin
            link_b.sda_m_oe = !b[i];
            q();
            link_b.scl_oe = 1'b0;
            q();
            q();
            link_b.scl_oe = 1'b1;
            q();
        end
        link_b.sda_m_oe = 1'b0;
        q();
        link_b.scl_oe = 1'b0;
        q();
        ack = (link_b.sda === 1'b0);
        q();
        link_b.scl_oe = 1'b1;
        q();
        check({7'h00, ack}, {7'h00, exp});
    endtask

    // Waits for a slave busy flag to drop
    task automatic wait_idle(input logic b_side);
        for (n = 0; n < 3 * NV_SIM && (b_side ? busy_b : busy_a) !== 1'b0; n++) begin
            @(posedge i_mclk);
            #1;
        end
        if (n == 3 * NV_SIM) give_up();
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge i_mclk);
        give_up();
    end

    // Main sequence
    initial begin
        i_rstn = 1'b0;
        i_req = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        link_b.scl_o = 1'b0;
        link_b.sda_m_o = 1'b0;
        link_b.scl_oe = 1'b0;
        link_b.sda_m_oe = 1'b0;
        n_fail = 0;
        comparisons = 0;
        rows[0] = '{1'b0, 8'h08, 8'h81, 8'h80};
        rows[1] = '{1'b1, 8'h08, 8'h00, 8'h80};
        rows[2] = '{1'b0, 8'h05, 8'hA5, 8'h80};
        rows[3] = '{1'b1, 8'h05, 8'h00, 8'hA5};
        rows[4] = '{1'b0, 8'h08, 8'h00, 8'h00};
        repeat (3) @(posedge i_mclk);
        #1;
        check({6'h00, link.sda_s_oe, link_b.sda_s_oe}, 8'h00);
        check(ctrl_a, 8'h00);
        i_rstn = 1'b1;
        // Start during power-up is ignored
        bb_start();
        bb_send(ID_W, 1'b0);
        bb_stop();
        // Foreign id, then a byte with no new start
        bb_start();
        bb_send({twi_cfg_pkg::DEV_CODE ^ 7'h01, 1'b0}, 1'b0);
        bb_send(8'h05, 1'b0);
        bb_stop();
        // Non-volatile write, then a start while the cycle runs
        bb_start();
        bb_send(ID_W, 1'b1);
        bb_send(8'h05, 1'b1);
        bb_send(8'h5A, 1'b1);
        bb_stop();
        check({7'h00, busy_b}, 8'h01);
        bb_start();
        bb_send(ID_W, 1'b0);
        bb_stop();
        wait_idle(1'b1);
        bb_start();
        bb_send(ID_W, 1'b1);
        bb_stop();
        // Ordinary writes and reads through the master end
        foreach (rows[k]) begin
            xfer(rows[k].rd, rows[k].addr, rows[k].wdata);
            check({7'h00, m_nack}, 8'h00);
            if (rows[k].rd) begin
                check(m_rdata, rows[k].exp);
            end else begin
                check(ctrl_a, rows[k].exp);
            end
            check({7'h00, busy_a}, 8'h00);
        end
        // Non-volatile write with busy bit shown, then read back
        xfer(1'b0, 8'h06, 8'hC3);
        repeat (8) @(posedge i_mclk);
        #1;
        check(ctrl_a, 8'h01);
        wait_idle(1'b0);
        repeat (2) @(posedge i_mclk);
        #1;
        check(ctrl_a, 8'h00);
        xfer(1'b1, 8'h06, 8'h00);
        check(m_rdata, 8'hC3);
        @(posedge i_mclk);
        #1;
        check({7'h00, m_busy}, 8'h00);
        finish_test();
    end
endmodule
